/* logic/readout_map.svh */
`ifndef READOUT_MAP_SVH
`define READOUT_MAP_SVH

// Factory slave address variants
`define ADDR_VARIANT_A 7'h28
`define ADDR_VARIANT_B 7'h36
`define ADDR_VARIANT_C 7'h46

// Header direction bit value for a read
`define READ_DIR 1'h1

// Status codes in the two top packet bits
`define STAT_STALE 2'h2

// Byte framing on the two-wire bus
`define BYTE_BITS 4'h8
`define LAST_BIT 4'h7
`define FIRST_BYTE 2'h0
`define LAST_BYTE 2'h3
`define FILL_BYTE 8'hff

// Packet layout
`define TEMP_PAD 5'h00
`define PKT_BITS 6'h20
`define PKT_MSB 5'h1f

// Idle levels of the synchronised pins {scl, sda, select_n, i2c_mode}
`define PIN_IDLE 4'he

`endif

/* logic/readout_pkg.sv */
`default_nettype none
package readout_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_IGNORE
  } i2c_state_t;

  // Byte 0 is the first byte on the wire and the most significant
  typedef logic [0:3][7:0] packet_t;

endpackage : readout_pkg
`default_nettype wire

/* logic/sync_stage.sv */
`timescale 1ns/10ps
`default_nettype none
module sync_stage #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Levels from another domain and their synchronised copies
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : sync_stage
`default_nettype wire

/* logic/pressure_readout.sv */
// Contract
// - Answer only the factory seven-bit slave address
// - Ready pin rises on new data, falls at start
// - Start condition makes the bus busy
// - Stop condition makes the bus free
// - Receiver pulls data low on ninth clock; data bytes after a write header get no acknowledge
// - Missing master acknowledge ends transmission, back idle
// - Bytes are eight bits, MSB first, then acknowledge
// - Direction bit decides who sends after header
// - Acknowledge own read header, then return data
// - Master picks fetch length by NACK and stop
// - Three bytes: status, bridge, eight-bit temperature
// - Fourth byte completes eleven-bit temperature, padded
// - Status 00 fresh, 10 already fetched
// - SPI output changes after falling, sampled rising
// - SPI packet is four bytes, fixed order
// - Master may end SPI frame early
// - Bridge is fourteen bits below two status bits
`timescale 1ns/10ps
`default_nettype none
`include "readout_map.svh"
module pressure_readout
  import readout_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = `ADDR_VARIANT_A
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Interface selection, high for the two-wire bus
  input wire logic i2c_mode,
  // Measurement source
  input wire logic new_result,
  input wire logic [13:0] bridge_data,
  input wire logic [10:0] temp_data,
  input wire logic [1:0] status_code,
  // Conversion request and state
  output logic meas_request,
  output logic busy,
  output logic fetched,
  // Data pin, SDA or MISO
  input wire logic sda_miso_in,
  output logic sda_miso_out,
  output logic sda_miso_oe,
  // Clock pin, SCL or SCLK
  input wire logic scl_sclk,
  // Ready pin in two-wire mode, active-low select in SPI mode
  input wire logic int_sel_in,
  output logic int_sel_out,
  output logic int_sel_oe
);

  logic rst_n;
  logic [3:0] pin_s;
  logic scl_s;
  logic sda_s;
  logic sel_n_s;
  logic i2c_s;
  logic scl_q;
  logic sda_q;
  logic sel_n_q;
  i2c_state_t state_q;
  i2c_state_t state_d;
  logic [3:0] bit_cnt_q;
  logic [3:0] bit_cnt_d;
  logic [1:0] byte_idx_q;
  logic [1:0] byte_idx_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic drive_low_q;
  logic drive_low_d;
  logic nack_q;
  logic nack_d;
  logic capture;
  logic write_hit;
  logic ready_q;
  logic fetched_q;
  logic meas_req_q;
  packet_t snap_q;
  packet_t live_pkt;
  logic [31:0] snap_flat;
  logic [1:0] status_bits;
  logic [5:0] spi_idx_q;
  logic miso_q;
  logic miso_en_q;

  sync_stage #(.WIDTH(1), .INIT(1'h0)) u_rst_sync (
    .clock(clock),
    .rst_n(nrst),
    .async_in(1'h1),
    .sync_out(rst_n)
  );

  sync_stage #(.WIDTH(4), .INIT(`PIN_IDLE)) u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({scl_sclk, sda_miso_in, int_sel_in, i2c_mode}),
    .sync_out(pin_s)
  );

  assign {scl_s, sda_s, sel_n_s, i2c_s} = pin_s;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      sel_n_q <= 1'h1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      sel_n_q <= sel_n_s;
    end
  end

  // Bus events, sampled well inside the slowest legal SCL phase
  wire scl_rise = i2c_s & scl_s & ~scl_q;
  wire scl_fall = i2c_s & ~scl_s & scl_q;
  wire start_det = i2c_s & scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det = i2c_s & scl_s & scl_q & ~sda_q & sda_s;
  wire addr_hit = shift_q[7:1] == SLAVE_ADDR;
  wire is_read = shift_q[0] == `READ_DIR;
  wire addr_done = state_q == ST_ADDR && scl_fall && bit_cnt_q == `BYTE_BITS;
  wire at_last = byte_idx_q == `LAST_BYTE;
  wire [1:0] next_idx = byte_idx_q + 2'h1;
  wire [7:0] next_byte = at_last ? `FILL_BYTE : snap_q[next_idx];
  wire spi_done = ~i2c_s & sel_n_s & ~sel_n_q;
  wire spi_idle = ~i2c_s & sel_n_s;

  assign status_bits = fetched_q ? `STAT_STALE : status_code;
  assign live_pkt = {status_bits, bridge_data, temp_data, `TEMP_PAD};
  assign snap_flat = snap_q;
  assign capture = addr_done & addr_hit & is_read;
  assign write_hit = addr_done & addr_hit & ~is_read;

  always_comb
  begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    byte_idx_d = byte_idx_q;
    shift_d = shift_q;
    tx_d = tx_q;
    drive_low_d = drive_low_q;
    nack_d = nack_q;
    if (start_det)
    begin
      state_d = ST_ADDR;
      bit_cnt_d = 4'h0;
      drive_low_d = 1'h0;
    end
    else if (stop_det)
    begin
      state_d = ST_IDLE;
      drive_low_d = 1'h0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          drive_low_d = 1'h0;
        end
        ST_ADDR:
        begin
          if (scl_rise)
          begin
            shift_d = {shift_q[6:0], sda_s};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end
          else if (addr_done)
          begin
            state_d = addr_hit ? ST_ADDR_ACK : ST_IDLE;
            drive_low_d = addr_hit;
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_d = 4'h0;
            byte_idx_d = `FIRST_BYTE;
            if (is_read)
            begin
              state_d = ST_TX;
              tx_d = snap_q[0];
              drive_low_d = ~snap_q[0][7];
            end
            else
            begin
              state_d = ST_IGNORE;
              drive_low_d = 1'h0;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_q == `LAST_BIT)
            begin
              state_d = ST_TX_ACK;
              drive_low_d = 1'h0;
            end
            else
            begin
              tx_d = {tx_q[6:0], 1'h1};
              bit_cnt_d = bit_cnt_q + 4'h1;
              drive_low_d = ~tx_q[6];
            end
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            nack_d = sda_s;
          end
          else if (scl_fall)
          begin
            if (nack_q)
            begin
              state_d = ST_IDLE;
            end
            else
            begin
              state_d = ST_TX;
              bit_cnt_d = 4'h0;
              byte_idx_d = at_last ? byte_idx_q : next_idx;
              tx_d = next_byte;
              drive_low_d = ~next_byte[7];
            end
          end
        end
        ST_IGNORE:
        begin
          drive_low_d = 1'h0;
        end
        default:
        begin
          state_d = ST_IDLE;
          drive_low_d = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      byte_idx_q <= `FIRST_BYTE;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      drive_low_q <= 1'h0;
      nack_q <= 1'h0;
    end
    else
    begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      byte_idx_q <= byte_idx_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      drive_low_q <= drive_low_d;
      nack_q <= nack_d;
    end
  end

  // Snapshot freezes for a whole SPI frame, so the link domain reads a
  // stable word; select falls long before the first SCLK edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      snap_q <= '0;
      ready_q <= 1'h0;
      fetched_q <= 1'h0;
      meas_req_q <= 1'h0;
    end
    else
    begin
      if (capture || spi_idle)
      begin
        snap_q <= live_pkt;
      end
      ready_q <= new_result | (ready_q & ~start_det);
      fetched_q <= capture | spi_done | (fetched_q & ~new_result);
      meas_req_q <= write_hit;
    end
  end

  // Link domain: select high clears it at once, so no edge is needed
  wire spi_clr = int_sel_in | ~rst_n | i2c_s;
  wire spi_end = spi_idx_q == `PKT_BITS;
  wire spi_bit = spi_end ? 1'h0 : snap_flat[`PKT_MSB - spi_idx_q[4:0]];

  always_ff @(negedge scl_sclk or posedge spi_clr)
  begin
    if (spi_clr)
    begin
      spi_idx_q <= 6'h00;
      miso_q <= 1'h0;
      miso_en_q <= 1'h0;
    end
    else
    begin
      miso_en_q <= 1'h1;
      miso_q <= spi_bit;
      spi_idx_q <= spi_end ? spi_idx_q : spi_idx_q + 6'h01;
    end
  end

  assign sda_miso_out = i2c_s ? 1'h0 : miso_q;
  assign sda_miso_oe = i2c_s ? drive_low_q : miso_en_q;
  assign int_sel_out = ready_q;
  assign int_sel_oe = i2c_s;
  assign meas_request = meas_req_q;
  assign busy = state_q != ST_IDLE;
  assign fetched = fetched_q;

  wire quiet = !start_det && !stop_det;

  sequence s_addr_reject;
    addr_done && !addr_hit && quiet;
  endsequence

  sequence s_read_ack;
    addr_done && addr_hit && is_read && quiet;
  endsequence

  property p_addr_reject;
    @(posedge clock) disable iff (!rst_n)
    s_addr_reject |=> state_q == ST_IDLE && !drive_low_q;
  endproperty
  a_addr_reject: assert property (p_addr_reject)
    else $error("foreign address not ignored");

  property p_ready_set;
    @(posedge clock) disable iff (!rst_n)
    new_result |=> ready_q && int_sel_out;
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("ready pin missed a new result");

  property p_ready_clr;
    @(posedge clock) disable iff (!rst_n)
    start_det && !new_result |=> !ready_q;
  endproperty
  a_ready_clr: assert property (p_ready_clr)
    else $error("ready pin not cleared at start");

  property p_start;
    @(posedge clock) disable iff (!rst_n)
    start_det |=> busy && state_q == ST_ADDR && bit_cnt_q == 4'h0;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not open a transaction");

  property p_stop;
    @(posedge clock) disable iff (!rst_n)
    stop_det |=> !busy && !drive_low_q;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not free the bus");

  property p_header_ack;
    @(posedge clock) disable iff (!rst_n)
    s_read_ack |=> drive_low_q && state_q == ST_ADDR_ACK && fetched_q;
  endproperty
  a_header_ack: assert property (p_header_ack)
    else $error("own read header not acknowledged");

  property p_first_bit;
    @(posedge clock) disable iff (!rst_n)
    state_q == ST_ADDR_ACK && is_read && scl_fall && quiet
      |=> state_q == ST_TX && drive_low_q == !snap_q[0][7];
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first data bit is not the packet MSB");

  property p_release_ack;
    @(posedge clock) disable iff (!rst_n)
    state_q == ST_TX && scl_fall && bit_cnt_q == `LAST_BIT && quiet
      |=> state_q == ST_TX_ACK && !drive_low_q;
  endproperty
  a_release_ack: assert property (p_release_ack)
    else $error("data line held during master acknowledge");

  property p_nack_idle;
    @(posedge clock) disable iff (!rst_n)
    state_q == ST_TX_ACK && nack_q && scl_fall && quiet
      |=> state_q == ST_IDLE ##1 !drive_low_q;
  endproperty
  a_nack_idle: assert property (p_nack_idle)
    else $error("transmission continued after a NACK");

  property p_stale;
    @(posedge clock) disable iff (!rst_n)
    capture |=> live_pkt[0][7:6] == `STAT_STALE;
  endproperty
  a_stale: assert property (p_stale)
    else $error("fetched packet not marked stale");

  property p_spi_hiz;
    @(posedge clock) disable iff (!rst_n)
    int_sel_in && !i2c_s |-> !sda_miso_oe;
  endproperty
  a_spi_hiz: assert property (p_spi_hiz)
    else $error("output driven while deselected");

  property p_spi_first;
    @(negedge scl_sclk) disable iff (spi_clr)
    spi_idx_q == 6'h01 |-> miso_q == snap_flat[31] && miso_en_q;
  endproperty
  a_spi_first: assert property (p_spi_first)
    else $error("SPI frame did not begin with packet MSB");

endmodule : pressure_readout
`default_nettype wire

/* testbench/bus_host.sv */
`timescale 1ns/10ps
`default_nettype none
module bus_host (
  // Pacing clock
  input wire logic clock,
  // Bus lines
  input wire logic sda_line,
  output logic scl_q,
  output logic sda_q,
  output logic sel_n_q
);
  // Long enough for the two-flop pin synchronisers to see every phase
  localparam int HALF = 8;

  initial
  begin
    scl_q = 1'b1;
    sda_q = 1'b1;
    sel_n_q = 1'b1;
  end

  task automatic wait_half();
    repeat (HALF) @(posedge clock);
    #2;
  endtask : wait_half

  // Data moves only while the clock is low, sampled at the end of high
  task automatic clock_bit(input logic v, output logic s);
    sda_q = v;
    wait_half();
    scl_q = 1'b1;
    wait_half();
    s = sda_line;
    scl_q = 1'b0;
  endtask : clock_bit

  task automatic start_cond();
    sda_q = 1'b1;
    wait_half();
    scl_q = 1'b1;
    wait_half();
    sda_q = 1'b0;
    wait_half();
    scl_q = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    sda_q = 1'b0;
    wait_half();
    scl_q = 1'b1;
    wait_half();
    sda_q = 1'b1;
    wait_half();
  endtask : stop_cond

  // A write sends tx and releases for the ack; a read sends all ones
  // and then last as its own ack, high for the final byte
  task automatic i2c_byte(input logic [7:0] tx, input logic last,
                          output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clock_bit(tx[i], s);
      rx[i] = s;
    end
    clock_bit(last, s);
    ack = ~s;
  endtask : i2c_byte

  task automatic spi_frame(input int nbits, output logic [31:0] rx);
    rx = '0;
    sel_n_q = 1'b0;
    #2600;
    for (int i = 0; i < nbits; i++)
    begin
      #16 scl_q = 1'b0;
      #16 scl_q = 1'b1;
      rx[31 - i] = sda_line;
    end
    #200;
    sel_n_q = 1'b1;
  endtask : spi_frame
endmodule : bus_host
`default_nettype wire

/* testbench/tb_pressure_readout.sv */
`timescale 1ns/10ps
`default_nettype none
`include "readout_map.svh"
`define CHK(what, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb_pressure_readout;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic i2c_mode = 1'b1;
  logic new_result = 1'b0;
  logic [13:0] bridge_data = '0;
  logic [10:0] temp_data = '0;
  logic [1:0] status_code = '0;
  int mr_count = 0;
  int bad_count = 0;
  int num_checks = 0;
  wire logic meas_request, busy, fetched, sda_miso_out, sda_miso_oe;
  wire logic int_sel_out, int_sel_oe, scl, sda_q, sel_n;
  // Pull-up on the data line, wired with both open-drain drivers
  wire logic sda_line = sda_q & ~(sda_miso_oe & ~sda_miso_out);
  wire logic int_line = int_sel_oe ? int_sel_out : sel_n;

  always #12.5 clock = ~clock;
  always @(posedge clock)
    if (meas_request)
      mr_count <= mr_count + 1;

  pressure_readout uut (.clock(clock), .nrst(nrst), .i2c_mode(i2c_mode),
    .new_result(new_result), .bridge_data(bridge_data),
    .temp_data(temp_data), .status_code(status_code),
    .meas_request(meas_request), .busy(busy), .fetched(fetched),
    .sda_miso_in(sda_line), .sda_miso_out(sda_miso_out),
    .sda_miso_oe(sda_miso_oe), .scl_sclk(scl), .int_sel_in(int_line),
    .int_sel_out(int_sel_out), .int_sel_oe(int_sel_oe));
  bus_host host (.clock(clock), .sda_line(sda_line), .scl_q(scl),
    .sda_q(sda_q), .sel_n_q(sel_n));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : step

  function automatic logic [31:0] pkt(input logic [1:0] s,
      input logic [13:0] b, input logic [10:0] t);
    return {s, b, t, `TEMP_PAD};
  endfunction : pkt

  task automatic load(input logic [1:0] s, input logic [13:0] b,
                      input logic [10:0] t);
    status_code = s;
    bridge_data = b;
    temp_data = t;
    new_result = 1'b1;
    step(1);
    new_result = 1'b0;
    step(3);
  endtask : load

  // Ready is only expected when a new result arrived since the last read
  task automatic read_i2c(input int n, input logic rdy,
                          input logic [31:0] exp);
    logic [7:0] rx;
    logic ack;
    `CHK("ready before start", rdy, int_line)
    host.start_cond();
    `CHK("ready after start", 1'b0, int_line)
    // Read header
    host.i2c_byte({`ADDR_VARIANT_A, `READ_DIR}, 1'b1, rx, ack);
    `CHK("header ack", 1'b1, ack)
    for (int i = 0; i < n; i++)
    begin
      host.i2c_byte(`FILL_BYTE, i == n - 1, rx, ack);
      `CHK("read byte", exp[31 - 8 * i -: 8], rx)
    end
    step(6);
    `CHK("idle after nack", 1'b0, busy)
    `CHK("released after nack", 1'b0, sda_miso_oe)
    host.stop_cond();
    $display("i2c read of %0d bytes done", n);
  endtask : read_i2c

  task automatic other_address();
    logic [7:0] rx;
    logic ack;
    logic [6:0] addr [2] = '{`ADDR_VARIANT_B, `ADDR_VARIANT_C};
    for (int i = 0; i < 2; i++)
    begin
      host.start_cond();
      host.i2c_byte({addr[i], `READ_DIR}, 1'b1, rx, ack);
      `CHK("foreign header ack", 1'b0, ack)
      host.stop_cond();
    end
    $display("foreign address test done");
  endtask : other_address

  task automatic write_header();
    logic [7:0] rx;
    logic ack;
    int mr_before;
    mr_before = mr_count;
    host.start_cond();
    host.i2c_byte({`ADDR_VARIANT_A, 1'b0}, 1'b1, rx, ack);
    `CHK("write header ack", 1'b1, ack)
    step(4);
    `CHK("measurement request", mr_before + 1, mr_count)
    host.i2c_byte(8'h00, 1'b1, rx, ack);
    `CHK("write data ack", 1'b0, ack)
    host.stop_cond();
    $display("measurement request test done");
  endtask : write_header

  task automatic read_spi(input int n, input logic [31:0] exp);
    logic [31:0] rx;
    host.spi_frame(n, rx);
    `CHK("spi frame", exp >> (32 - n), rx >> (32 - n))
    step(5);
    `CHK("miso released", 1'b0, sda_miso_oe)
    `CHK("stale after frame", 1'b1, fetched)
    $display("spi read of %0d bits done", n);
  endtask : read_spi

  initial
  begin
    step(10);
    nrst = 1'b1;
    step(10);
    load(2'h0, 14'h2a5c, 11'h5b3);
    read_i2c(4, 1'b1, pkt(2'h0, 14'h2a5c, 11'h5b3));
    read_i2c(2, 1'b0, pkt(`STAT_STALE, 14'h2a5c, 11'h5b3));
    load(2'h1, 14'h1357, 11'h2c9);
    read_i2c(3, 1'b1, pkt(2'h1, 14'h1357, 11'h2c9));
    other_address();
    write_header();
    i2c_mode = 1'b0;
    step(8);
    `CHK("ready pin off in spi", 1'b0, int_sel_oe)
    load(2'h0, 14'h3c0f, 11'h7a5);
    read_spi(32, pkt(2'h0, 14'h3c0f, 11'h7a5));
    read_spi(16, pkt(`STAT_STALE, 14'h3c0f, 11'h7a5));
    read_spi(24, pkt(`STAT_STALE, 14'h3c0f, 11'h7a5));
    report_and_stop();
  end

  // The whole sequence needs well under 150 us
  initial
  begin
    #1_000_000;
    $display("watchdog expired");
    bad_count++;
    report_and_stop();
  end
endmodule : tb_pressure_readout
`default_nettype wire
